// *** sit_pkg.sv ***
// Constants and types for the sleep interval timer
package sit_pkg;
   // ****************************************************************
   // Register offsets
   // ****************************************************************
   localparam logic [9:0] WAKE_LOW_OFS   = 10'h222;
   localparam logic [9:0] WAKE_HIGH_OFS  = 10'h223;
   localparam logic [9:0] FINE_LOW_OFS   = 10'h224;
   localparam logic [9:0] FINE_HIGH_OFS  = 10'h225;
   localparam logic [9:0] COARSE_B0_OFS  = 10'h226;
   localparam logic [9:0] COARSE_B1_OFS  = 10'h227;
   localparam logic [9:0] COARSE_B2_OFS  = 10'h228;
   localparam logic [9:0] COARSE_TOP_OFS = 10'h229;
   localparam logic [9:0] LP_CTRL_OFS    = 10'h2f0;
   localparam logic [9:0] STATUS_OFS     = 10'h2f1;
   // ****************************************************************
   // Field positions and widths
   // ****************************************************************
   localparam int WAKE_W         = 11;
   localparam int FINE_W         = 16;
   localparam int COARSE_W       = 26;
   localparam int WAKE_HIGH_MSB  = 2;
   localparam int COARSE_TOP_MSB = 1;
   localparam int TRIGGER_BIT    = 7;
   localparam int DIV_MSB        = 4;
   localparam int SOURCE_BIT     = 6;
   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [10:0] WAKE_RESET    = 11'h00a;
   localparam logic [15:0] FINE_RESET    = 16'h0000;
   localparam logic [25:0] COARSE_RESET  = 26'h0000000;
   localparam logic [7:0]  LP_CTRL_RESET = 8'h00;
   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int SYS_CLK_PERIOD_NS = 50;
   localparam int FINE_TICK_NS      = 50;
   localparam int FINE_TICK_CYCLES  = (FINE_TICK_NS / SYS_CLK_PERIOD_NS < 1) ? 1 :
                                      FINE_TICK_NS / SYS_CLK_PERIOD_NS;
   localparam logic [3:0] FINE_TICK_LAST = 4'(FINE_TICK_CYCLES - 1);
   // ****************************************************************
   // Sequencer states
   // ****************************************************************
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_COARSE = 2'b01,
      ST_FINE   = 2'b10
   } sit_state_e;
endpackage : sit_pkg

// *** sit_sleep_timer.sv ***
// Sleep interval timer: coarse sleep-clock counter, fine tick counter, wake match
`timescale 1ns/10ps
`default_nettype none
module sit_sleep_timer (
   input  wire logic       sys_clk,
   input  wire logic       rstn,
   input  wire logic [9:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output var  logic [7:0] reg_rdata,
   input  wire logic       ext_sleep_clk,
   input  wire logic       int_osc_clk,
   input  wire logic       interval_start,
   output var  logic       main_osc_enable,
   output var  logic       sleep_active,
   output var  logic       interval_done
);
   // ****************************************************************
   // Decoding
   // ****************************************************************
   function automatic logic hit(input logic [9:0] a, input logic [9:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   function automatic logic [30:0] low_mask(input logic [4:0] n);
      low_mask = 31'((32'h1 << n) - 32'h1);
   endfunction : low_mask

   // ****************************************************************
   // Registers
   // ****************************************************************
   logic [10:0]         wake_match_value;
   logic [15:0]         fine_cfg;
   logic [25:0]         coarse_cfg;
   logic [7:0]          lp_ctrl;
   sit_pkg::sit_state_e state;
   sit_pkg::sit_state_e next_state;
   logic [25:0]         coarse_sleep_count;
   logic [25:0]         next_coarse;
   logic [15:0]         fine_tick_count;
   logic [15:0]         next_fine;
   logic [3:0]          tick_cnt;
   logic [2:0]          clk_sync;
   logic                clk_level;
   logic [30:0]         div_cnt;
   logic [7:0]          next_rdata;
   logic                next_osc;
   logic                next_done;

   wire logic [4:0] low_power_clock_divisor = lp_ctrl[sit_pkg::DIV_MSB:0];
   wire logic       low_power_clock_source  = lp_ctrl[sit_pkg::SOURCE_BIT];
   wire logic       wr_top      = reg_wr && hit(reg_addr, sit_pkg::COARSE_TOP_OFS);
   wire logic       sleep_timer_trigger = wr_top && reg_wdata[sit_pkg::TRIGGER_BIT];
   wire logic       start       = sleep_timer_trigger || interval_start;
   wire logic [25:0] start_load = wr_top ?
      {reg_wdata[sit_pkg::COARSE_TOP_MSB:0], coarse_cfg[23:0]} : coarse_cfg;
   wire logic [25:0] wake_ext   = {15'h0000, wake_match_value};
   wire logic       fine_tick   = (tick_cnt == sit_pkg::FINE_TICK_LAST);

   // Write side; reserved bits are not stored so they read back as zero
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         wake_match_value <= sit_pkg::WAKE_RESET;
         fine_cfg         <= sit_pkg::FINE_RESET;
         coarse_cfg       <= sit_pkg::COARSE_RESET;
         lp_ctrl          <= sit_pkg::LP_CTRL_RESET;
      end else if (reg_wr) begin
         if (hit(reg_addr, sit_pkg::WAKE_LOW_OFS))
            wake_match_value[7:0] <= reg_wdata;
         if (hit(reg_addr, sit_pkg::WAKE_HIGH_OFS))
            wake_match_value[10:8] <= reg_wdata[sit_pkg::WAKE_HIGH_MSB:0];
         if (hit(reg_addr, sit_pkg::FINE_LOW_OFS))
            fine_cfg[7:0] <= reg_wdata;
         if (hit(reg_addr, sit_pkg::FINE_HIGH_OFS))
            fine_cfg[15:8] <= reg_wdata;
         if (hit(reg_addr, sit_pkg::COARSE_B0_OFS))
            coarse_cfg[7:0] <= reg_wdata;
         if (hit(reg_addr, sit_pkg::COARSE_B1_OFS))
            coarse_cfg[15:8] <= reg_wdata;
         if (hit(reg_addr, sit_pkg::COARSE_B2_OFS))
            coarse_cfg[23:16] <= reg_wdata;
         if (wr_top)
            coarse_cfg[25:24] <= reg_wdata[sit_pkg::COARSE_TOP_MSB:0];
         if (hit(reg_addr, sit_pkg::LP_CTRL_OFS))
            lp_ctrl <= reg_wdata & 8'h5f;
      end
   end

   // Read side; the trigger bit never reads back, it lives only in the write cycle
   always_comb begin
      next_rdata = 8'h00;
      if (reg_rd) begin
         if (hit(reg_addr, sit_pkg::WAKE_LOW_OFS))   next_rdata = wake_match_value[7:0];
         if (hit(reg_addr, sit_pkg::WAKE_HIGH_OFS))  next_rdata = {5'h00, wake_match_value[10:8]};
         if (hit(reg_addr, sit_pkg::FINE_LOW_OFS))   next_rdata = fine_cfg[7:0];
         if (hit(reg_addr, sit_pkg::FINE_HIGH_OFS))  next_rdata = fine_cfg[15:8];
         if (hit(reg_addr, sit_pkg::COARSE_B0_OFS))  next_rdata = coarse_cfg[7:0];
         if (hit(reg_addr, sit_pkg::COARSE_B1_OFS))  next_rdata = coarse_cfg[15:8];
         if (hit(reg_addr, sit_pkg::COARSE_B2_OFS))  next_rdata = coarse_cfg[23:16];
         if (hit(reg_addr, sit_pkg::COARSE_TOP_OFS)) next_rdata = {6'h00, coarse_cfg[25:24]};
         if (hit(reg_addr, sit_pkg::LP_CTRL_OFS))    next_rdata = lp_ctrl;
         if (hit(reg_addr, sit_pkg::STATUS_OFS))
            next_rdata = {5'h00, main_osc_enable, state};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn)
         reg_rdata <= 8'h00;
      else
         reg_rdata <= next_rdata;
   end

   // ****************************************************************
   // Low-power clock
   // ****************************************************************
   // The source mux sits ahead of the synchroniser; a source switch may
   // cost or add one sleep clock edge, so change it only while idle.
   wire logic src_clk  = low_power_clock_source ? int_osc_clk : ext_sleep_clk;
   wire logic agree    = (clk_sync[1] == clk_sync[2]);
   wire logic src_rise = agree && clk_sync[1] && !clk_level;
   wire logic [30:0] div_mask = low_mask(low_power_clock_divisor);
   wire logic lp_tick  = src_rise && ((div_cnt[30:0] & div_mask) == div_mask);

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         clk_sync  <= 3'h0;
         clk_level <= 1'b0;
         div_cnt   <= 31'h00000000;
      end else begin
         clk_sync <= {clk_sync[1:0], src_clk};
         if (agree)
            clk_level <= clk_sync[1];
         if (src_rise)
            div_cnt <= div_cnt + 31'h00000001;
      end
   end

   // ****************************************************************
   // Interval sequencer
   // ****************************************************************
   always_comb begin
      next_state = state;
      next_coarse = coarse_sleep_count;
      next_fine = fine_tick_count;
      next_done = 1'b0;
      unique case (state)
         sit_pkg::ST_IDLE: begin
            if (start) begin
               next_state  = sit_pkg::ST_COARSE;
               next_coarse = start_load;
               next_fine   = fine_cfg;
            end
         end
         sit_pkg::ST_COARSE: begin
            if (coarse_sleep_count == 26'h0000000)
               next_state = sit_pkg::ST_FINE;
            else if (lp_tick)
               next_coarse = coarse_sleep_count - 26'h0000001;
         end
         sit_pkg::ST_FINE: begin
            if (fine_tick_count == 16'h0000) begin
               next_state = sit_pkg::ST_IDLE;
               next_done  = 1'b1;
            end else if (fine_tick) begin
               next_fine = fine_tick_count - 16'h0001;
            end
         end
         default: next_state = sit_pkg::ST_IDLE;
      endcase
   end

   // Compare with less-or-equal so a wake value above the loaded count
   // still wakes at once instead of being missed.
   assign next_osc = (next_state != sit_pkg::ST_COARSE) || (next_coarse <= wake_ext);

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         state              <= sit_pkg::ST_IDLE;
         coarse_sleep_count <= sit_pkg::COARSE_RESET;
         fine_tick_count    <= sit_pkg::FINE_RESET;
         tick_cnt           <= 4'h0;
         main_osc_enable    <= 1'b1;
         sleep_active       <= 1'b0;
         interval_done      <= 1'b0;
      end else begin
         state              <= next_state;
         coarse_sleep_count <= next_coarse;
         fine_tick_count    <= next_fine;
         tick_cnt           <= (state != sit_pkg::ST_FINE || fine_tick) ? 4'h0 :
                               tick_cnt + 4'h1;
         main_osc_enable    <= next_osc;
         sleep_active       <= (next_state != sit_pkg::ST_IDLE);
         interval_done      <= next_done;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_trigger_start;
      @(posedge sys_clk) disable iff (!rstn)
      (state == sit_pkg::ST_IDLE && sleep_timer_trigger) |=> (state == sit_pkg::ST_COARSE);
   endproperty
   a_trigger_start: assert property (p_trigger_start)
      else $error("Trigger did not start the coarse phase");

   property p_trigger_reads_zero;
      @(posedge sys_clk) disable iff (!rstn)
      (reg_rd && hit(reg_addr, sit_pkg::COARSE_TOP_OFS)) |=> (reg_rdata[7:2] == 6'h00);
   endproperty
   a_trigger_reads_zero: assert property (p_trigger_reads_zero)
      else $error("Trigger or reserved bits read as one");

   property p_wake_reset;
      @(posedge sys_clk) !rstn |=> (wake_match_value == 11'h00a);
   endproperty
   a_wake_reset: assert property (p_wake_reset)
      else $error("Wake value reset wrong");

   property p_osc_wake;
      @(posedge sys_clk) disable iff (!rstn)
      (state == sit_pkg::ST_COARSE && coarse_sleep_count > wake_ext) |-> !main_osc_enable;
   endproperty
   a_osc_wake: assert property (p_osc_wake)
      else $error("Oscillator on before wake match");

   property p_osc_on_match;
      @(posedge sys_clk) disable iff (!rstn)
      (state == sit_pkg::ST_COARSE && coarse_sleep_count == wake_ext) |-> main_osc_enable;
   endproperty
   a_osc_on_match: assert property (p_osc_on_match)
      else $error("Oscillator off at wake match");

   property p_coarse_hold;
      @(posedge sys_clk) disable iff (!rstn)
      (state == sit_pkg::ST_COARSE && !lp_tick) |=> $stable(coarse_sleep_count);
   endproperty
   a_coarse_hold: assert property (p_coarse_hold)
      else $error("Coarse count moved without a sleep tick");

   property p_fine_step;
      @(posedge sys_clk) disable iff (!rstn)
      (state == sit_pkg::ST_FINE && fine_tick_count != 16'h0000 && fine_tick)
      |=> (fine_tick_count == $past(fine_tick_count) - 16'h0001);
   endproperty
   a_fine_step: assert property (p_fine_step)
      else $error("Fine count did not step by one tick");

   property p_coarse_then_fine;
      @(posedge sys_clk) disable iff (!rstn)
      (state == sit_pkg::ST_COARSE && coarse_sleep_count == 26'h0000000)
      |=> (state == sit_pkg::ST_FINE) ##0 main_osc_enable;
   endproperty
   a_coarse_then_fine: assert property (p_coarse_then_fine)
      else $error("Fine phase did not follow coarse phase");

   // Helper for the divisor check: sleep clock rises since the last tick.
   // A divisor write voids the gap, since the free divider is not realigned.
   wire logic   lp_ctrl_wr = reg_wr && hit(reg_addr, sit_pkg::LP_CTRL_OFS);
   logic [31:0] rise_gap;
   logic        gap_valid;

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         rise_gap  <= 32'h00000000;
         gap_valid <= 1'b0;
      end else begin
         if (lp_tick)
            rise_gap <= 32'h00000000;
         else if (src_rise)
            rise_gap <= rise_gap + 32'h00000001;
         if (lp_ctrl_wr)
            gap_valid <= 1'b0;
         else if (lp_tick)
            gap_valid <= 1'b1;
      end
   end

   property p_div_tick;
      @(posedge sys_clk) disable iff (!rstn)
      (lp_tick && gap_valid)
      |-> ((rise_gap + 32'h00000001) == (32'h00000001 << low_power_clock_divisor));
   endproperty
   a_div_tick: assert property (p_div_tick)
      else $error("Sleep tick off the divisor boundary");

   property p_high_reserved;
      @(posedge sys_clk) disable iff (!rstn)
      (reg_rd && hit(reg_addr, sit_pkg::WAKE_HIGH_OFS)) |=> (reg_rdata[7:3] == 5'h00);
   endproperty
   a_high_reserved: assert property (p_high_reserved)
      else $error("Wake high reserved bits not zero");

   property p_done_pulse;
      @(posedge sys_clk) disable iff (!rstn)
      interval_done |-> !sleep_active ##1 !interval_done;
   endproperty
   a_done_pulse: assert property (p_done_pulse)
      else $error("Interval done not a single pulse");

   property p_osc_idle;
      @(posedge sys_clk) disable iff (!rstn)
      (state == sit_pkg::ST_IDLE) |-> main_osc_enable;
   endproperty
   a_osc_idle: assert property (p_osc_idle)
      else $error("Oscillator off while idle");

   property p_wake_high_write;
      @(posedge sys_clk) disable iff (!rstn)
      (reg_wr && hit(reg_addr, sit_pkg::WAKE_HIGH_OFS))
      |=> (wake_match_value[10:8] == $past(reg_wdata[sit_pkg::WAKE_HIGH_MSB:0]));
   endproperty
   a_wake_high_write: assert property (p_wake_high_write)
      else $error("Wake high bits not taken from the write");

   property p_fine_load;
      @(posedge sys_clk) disable iff (!rstn)
      (state == sit_pkg::ST_IDLE && start)
      |=> (fine_tick_count == $past(fine_cfg));
   endproperty
   a_fine_load: assert property (p_fine_load)
      else $error("Fine count not loaded at start");

   property p_coarse_load;
      @(posedge sys_clk) disable iff (!rstn)
      (state == sit_pkg::ST_IDLE && sleep_timer_trigger)
      |=> (coarse_sleep_count[25:24] == $past(reg_wdata[1:0]))
          && (coarse_sleep_count[23:0] == $past(coarse_cfg[23:0]));
   endproperty
   a_coarse_load: assert property (p_coarse_load)
      else $error("Coarse count not loaded from the trigger write");

   c_trigger: cover property (@(posedge sys_clk) disable iff (!rstn) sleep_timer_trigger);
   c_wake: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(main_osc_enable));
   c_done: cover property (@(posedge sys_clk) disable iff (!rstn) interval_done);
   c_beacon: cover property (@(posedge sys_clk) disable iff (!rstn)
      interval_start && state == sit_pkg::ST_IDLE);
endmodule : sit_sleep_timer
`default_nettype wire

// *** sit_sleep_timer_tb_top.sv ***
// Self-checking testbench for the sleep interval timer
`timescale 1ns/10ps
`default_nettype none
module sit_sleep_timer_tb_top;
   // ************************************************************
   // Signals
   // ************************************************************
   logic       sys_clk = 1'b0;
   logic       rstn;
   logic [9:0] reg_addr;
   logic [7:0] reg_wdata;
   logic       reg_wr;
   logic       reg_rd;
   logic [7:0] reg_rdata;
   logic       ext_sleep_clk;
   logic       int_osc_clk;
   logic       interval_start;
   logic       main_osc_enable;
   logic       sleep_active;
   logic       interval_done;
   logic       lp_src;
   logic [7:0] ph = 8'h00;
   logic [7:0] shadow [8];
   logic [7:0] rd_val;
   logic [7:0] d;
   logic [15:0] fine;
   int         edges = 0;
   int         failures;
   int         num_checks;
   int         seed;
   int         done_at;
   int         osc_e;
   int         done_e;

   sit_sleep_timer i_sit_sleep_timer (
      .sys_clk         (sys_clk),
      .rstn            (rstn),
      .reg_addr        (reg_addr),
      .reg_wdata       (reg_wdata),
      .reg_wr          (reg_wr),
      .reg_rd          (reg_rd),
      .reg_rdata       (reg_rdata),
      .ext_sleep_clk   (ext_sleep_clk),
      .int_osc_clk     (int_osc_clk),
      .interval_start  (interval_start),
      .main_osc_enable (main_osc_enable),
      .sleep_active    (sleep_active),
      .interval_done   (interval_done)
   );

   always #25 sys_clk = ~sys_clk;

   // Selected source has a 16-cycle period; the other runs fast so a wrong mux shows
   assign ext_sleep_clk = lp_src ? ph[1] : ph[3];
   assign int_osc_clk   = lp_src ? ph[3] : ph[1];
   always @(posedge sys_clk) begin
      ph <= ph + 8'h01;
      if (ph[3:0] == 4'h7) edges <= edges + 1;
   end

   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   task automatic tally_and_finish();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : tally_and_finish

   task automatic reg_write(input logic [9:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [9:0] a, output logic [7:0] v);
      @(posedge sys_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
   endtask : reg_read

   function automatic logic [7:0] rd_mask(input int idx);
      return (idx == 1) ? 8'h07 : (idx == 7) ? 8'h03 : 8'hff;
   endfunction : rd_mask

   // Start aligned just after a sleep clock edge so edge counts are unambiguous
   task automatic run_interval(input logic       use_pin,
                               input logic       retrig,
                               input logic [7:0] st_exp);
      int e0;
      done_at = -1;
      osc_e   = -1;
      do @(posedge sys_clk); while (ph[3:0] != 4'h0);
      if (use_pin) interval_start <= 1'b1;
      else begin
         reg_wr    <= 1'b1;
         reg_addr  <= sit_pkg::COARSE_TOP_OFS;
         reg_wdata <= 8'h80 | shadow[7];
      end
      @(posedge sys_clk);
      interval_start <= 1'b0;
      reg_wr         <= 1'b0;
      #1;
      e0 = edges;
      check("sleep_active at start", sleep_active, 1'b1);
      for (int n = 1; n < 4000 && done_at < 0; n++) begin
         @(posedge sys_clk);
         interval_start <= retrig && n == 1;
         reg_rd         <= (n == 1);
         reg_addr       <= sit_pkg::STATUS_OFS;
         #1;
         if (n == 2) check("status in run", reg_rdata, st_exp);
         if (main_osc_enable === 1'b1 && osc_e < 0) osc_e = edges - e0;
         if (interval_done === 1'b1) begin
            done_at = n;
            done_e  = edges - e0;
            check("sleep_active at done", sleep_active, 1'b0);
         end
      end
      if (done_at < 0) begin
         failures++;
         tally_and_finish();
      end else begin
         @(posedge sys_clk);
         #1;
         check("done pulse width", interval_done, 1'b0);
      end
   endtask : run_interval

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      rstn = 1'b0;
      reg_addr = 10'h000;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      interval_start = 1'b0;
      lp_src = 1'b0;
      failures = 0;
      num_checks = 0;
      seed = 32'heb2d7501;
      repeat (5) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      #1;
      check("osc enable idle", main_osc_enable, 1'b1);
      check("sleep_active idle", sleep_active, 1'b0);
      for (int i = 0; i < 8; i++) begin
         reg_read(sit_pkg::WAKE_LOW_OFS + 10'(i), rd_val);
         check("reset value", rd_val, (i == 0) ? 8'h0a : 8'h00);
      end
      reg_read(sit_pkg::LP_CTRL_OFS, rd_val);
      check("lp_ctrl reset", rd_val, 8'h00);
      reg_read(sit_pkg::STATUS_OFS, rd_val);
      check("status idle", rd_val, 8'h04);
      // Random traffic, reserved bits and an unmapped place among it
      for (int k = 0; k < 12; k++) begin
         for (int i = 0; i < 8; i++) begin
            d = 8'($random(seed));
            if (i == 7) d[7] = 1'b0;
            if (i == 0 && d == 8'h00) d = 8'h01;
            reg_write(sit_pkg::WAKE_LOW_OFS + 10'(i), d);
            shadow[i] = d & rd_mask(i);
         end
         reg_write(10'h230, 8'($random(seed)));
         for (int i = 0; i < 8; i++) begin
            reg_read(sit_pkg::WAKE_LOW_OFS + 10'(i), rd_val);
            check("register readback", rd_val, shadow[i]);
         end
         reg_read(10'h230, rd_val);
         check("unmapped read", rd_val, 8'h00);
      end
      reg_write(sit_pkg::LP_CTRL_OFS, 8'hff);
      reg_read(sit_pkg::LP_CTRL_OFS, rd_val);
      check("lp_ctrl readback", rd_val, 8'h5f);
      // Coarse count zero: fine phase alone, one long case using the high byte
      for (int i = 4; i < 7; i++) reg_write(sit_pkg::WAKE_LOW_OFS + 10'(i), 8'h00);
      shadow[7] = 8'h00;
      for (int k = 0; k < 6; k++) begin
         fine = (k == 0) ? 16'h0100 : {10'h000, 6'($random(seed))};
         reg_write(sit_pkg::FINE_LOW_OFS, fine[7:0]);
         reg_write(sit_pkg::FINE_HIGH_OFS, fine[15:8]);
         run_interval(k[0], k == 3, 8'h06);
         check("fine phase length", done_at, 32'(fine) + 32'd2);
         check("osc stays on", osc_e, 0);
      end
      reg_read(sit_pkg::COARSE_TOP_OFS, rd_val);
      check("trigger self clears", rd_val, 8'h00);
      // Coarse 6 against wake 2, both clock sources and two divisors
      reg_write(sit_pkg::WAKE_LOW_OFS, 8'h02);
      reg_write(sit_pkg::WAKE_HIGH_OFS, 8'h00);
      reg_write(sit_pkg::FINE_LOW_OFS, 8'h02);
      reg_write(sit_pkg::FINE_HIGH_OFS, 8'h00);
      reg_write(sit_pkg::COARSE_B0_OFS, 8'h06);
      for (int k = 0; k < 2; k++) begin
         lp_src <= k[0];
         reg_write(sit_pkg::LP_CTRL_OFS, k[0] ? 8'h41 : 8'h02);
         run_interval(1'b0, 1'b0, 8'h01);
         check("wake to zero edges", done_e - osc_e, k[0] ? 4 : 8);
         check("coarse edges", done_e > (k[0] ? 10 : 20) && done_e <= (k[0] ? 12 : 24),
               1'b1);
      end
      tally_and_finish();
   end
endmodule : sit_sleep_timer_tb_top
`default_nettype wire
